/* File: common/cbst_pkg.sv */
package cbst_pkg;
  localparam int DW = 32;
  localparam int SAW = 4;
  localparam int STK_DEPTH = 16;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_IP     = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_OPND   = 8'h10;
  localparam logic [7:0] OFS_LEN    = 8'h14;
  localparam logic [7:0] OFS_BLO    = 8'h18;
  localparam logic [7:0] OFS_BHI    = 8'h1C;
  localparam logic [7:0] OFS_VALUE  = 8'h20;
  localparam logic [7:0] OFS_SP     = 8'h24;
  localparam logic [7:0] OFS_VBASE  = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int CMD_A16_BIT = 8;
  localparam int ZF_BIT = 0;
  localparam int OF_BIT = 1;
  localparam logic [7:0] OVF_VEC   = 8'h10;
  localparam logic [7:0] RANGE_VEC = 8'h11;
  localparam logic [SAW-1:0] RST_SP = 4'h0;
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [3:0] {
    OP_NOP, OP_LOOP, OP_LOOP_EQ, OP_LOOP_NE, OP_JCX32,
    OP_JCX16, OP_INT, OP_INTO, OP_BOUND, OP_HANDLER_RETURN
  } cbst_op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_PUSH_FL, ST_PUSH_IP, ST_POP_IP, ST_POP_FL
  } cbst_state_t;
  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] o,
                                             input logic [DW-1:0] n,
                                             input logic [3:0] be);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction
  function automatic logic [DW-1:0] rel_target(input logic [DW-1:0] p,
                                               input logic [DW-1:0] l,
                                               input logic [DW-1:0] r);
    return p + l + r;
  endfunction
endpackage

/* File: common/cbst_stk_if.sv */
`timescale 1ns/100ps
interface cbst_stk_if;
  logic          we;
  logic [3:0]    addr;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  modport mst (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* File: dv/tb_counted_branch_soft_trap.sv */
`timescale 1ns/100ps
module tb_counted_branch_soft_trap import cbst_pkg::*;;
  logic        i_core_clk;
  logic        i_reset_n;
  logic [7:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        o_busy;
  int          bad_count;
  int          checked;
  int          busy_cycles;
  logic [31:0] v;

  cbst_core uut (
    .i_core_clk        (i_core_clk),
    .i_reset_n         (i_reset_n),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_busy            (o_busy)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // ------------------------------------------------------------
  // bus access and compare
  // ------------------------------------------------------------
  // request held until an edge sees waitrequest low; pre-edge values are read, inputs move by nba
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= 1'b1;
    @(posedge i_core_clk);
    while (o_avs_waitrequest !== 1'b0) begin
      w++;
      @(posedge i_core_clk);
    end
    i_avs_write <= 1'b0;
    chk("write waits", 32'h0000_0000, 32'(w));
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    int w;
    w = 0;
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_read <= 1'b1;
    @(posedge i_core_clk);
    while (o_avs_waitrequest !== 1'b0) begin
      w++;
      @(posedge i_core_clk);
    end
    d = o_avs_readdata;
    i_avs_read <= 1'b0;
    chk("read waits", 32'h0000_0001, 32'(w));
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_read(a, d);
    chk(name, exp, d);
  endtask

  // ------------------------------------------------------------
  // command helpers
  // ------------------------------------------------------------
  task automatic exec(input cbst_op_t op, input logic a16);
    bus_write(OFS_CMD, {23'h000000, a16, 4'h0, 4'(op)});
    busy_cycles = 0;
    do begin
      @(posedge i_core_clk);
      if (o_busy === 1'b1) busy_cycles++;
    end while (o_busy !== 1'b0);
  endtask

  task automatic do_op(input cbst_op_t op, input logic a16, input logic [31:0] cnt, input logic [31:0] fl);
    bus_write(OFS_IP, 32'h0000_0100);
    bus_write(OFS_COUNT, cnt);
    bus_write(OFS_FLAGS, fl);
    exec(op, a16);
  endtask

  // target is ip 100 + len 2 - 10
  task automatic br_chk(input logic [31:0] cnt, input logic tk);
    logic [31:0] d;
    chk("busy", 32'h0000_0001, 32'(busy_cycles));
    rd_chk("count", OFS_COUNT, cnt);
    rd_chk("ip", OFS_IP, tk ? 32'h0000_00F8 : 32'h0000_0102);
    bus_read(OFS_STATUS, d);
    chk("taken", {31'h0, tk}, {31'h0, d[1]});
  endtask

  task automatic trap_chk(input logic [31:0] ip, input logic tr, input logic [7:0] vec);
    logic [31:0] d;
    chk("busy", tr ? 32'h0000_0003 : 32'h0000_0001, 32'(busy_cycles));
    rd_chk("ip", OFS_IP, ip);
    bus_read(OFS_STATUS, d);
    chk("trapped", {31'h0, tr}, {31'h0, d[2]});
    if (tr) chk("vector", {24'h0, vec}, {24'h0, d[15:8]});
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0;
    i_avs_address = 8'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'hF;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd_chk("count rst", OFS_COUNT, 32'h0000_0000);
    rd_chk("sp rst", OFS_SP, 32'h0000_0000);
    rd_chk("unmapped", 8'h30, 32'h0000_0000);
    bus_write(OFS_LEN, 32'h0000_0002);
    bus_write(OFS_OPND, 32'hFFFF_FFF6);
    bus_write(OFS_VBASE, 32'h0000_1000);
    do_op(OP_LOOP, 1'b0, 32'h0000_0005, 32'h0000_0001);
    br_chk(32'h0000_0004, 1'b1);
    rd_chk("flags kept", OFS_FLAGS, 32'h0000_0001);
    do_op(OP_LOOP, 1'b0, 32'h0000_0001, 32'h0000_0000);
    br_chk(32'h0000_0000, 1'b0);
    do_op(OP_LOOP, 1'b0, 32'h0000_0000, 32'h0000_0000);
    br_chk(32'hFFFF_FFFF, 1'b1);
    do_op(OP_LOOP, 1'b1, 32'hABCD_0001, 32'h0000_0000);
    br_chk(32'hABCD_0000, 1'b0);
    do_op(OP_LOOP, 1'b1, 32'h1234_0000, 32'h0000_0000);
    br_chk(32'h1234_FFFF, 1'b1);
    rd_chk("cmd", OFS_CMD, 32'h0000_0101);
    for (int z = 0; z < 2; z++) begin
      for (int c = 1; c < 4; c += 2) begin
        do_op(OP_LOOP_EQ, 1'b0, 32'(c), 32'(z));
        br_chk(32'(c - 1), (c != 1) && (z == 1));
        do_op(OP_LOOP_NE, 1'b0, 32'(c), 32'(z));
        br_chk(32'(c - 1), (c != 1) && (z == 0));
        rd_chk("flags kept", OFS_FLAGS, 32'(z));
      end
    end
    for (int f = 0; f < 4; f++) begin
      do_op(OP_JCX32, 1'b0, 32'h0000_0000, 32'(f));
      br_chk(32'h0000_0000, 1'b1);
      do_op(OP_JCX32, 1'b0, 32'h0000_0007, 32'(f));
      br_chk(32'h0000_0007, 1'b0);
      do_op(OP_JCX16, 1'b1, 32'h0001_0000, 32'(f));
      br_chk(32'h0001_0000, 1'b1);
      do_op(OP_JCX16, 1'b1, 32'h0000_0001, 32'(f));
      br_chk(32'h0000_0001, 1'b0);
    end
    // vectored trap then return, stack seen only through the return
    bus_write(OFS_SP, 32'h0000_0000);
    bus_write(OFS_OPND, 32'h0000_0021);
    do_op(OP_INT, 1'b0, 32'h0000_0009, 32'h0000_0003);
    trap_chk(32'h0000_1084, 1'b1, 8'h21);
    rd_chk("sp push", OFS_SP, 32'h0000_000E);
    bus_write(OFS_FLAGS, 32'h0000_0000);
    bus_write(OFS_IP, 32'h0000_5555);
    exec(OP_HANDLER_RETURN, 1'b0);
    chk("ret busy", 32'h0000_0003, 32'(busy_cycles));
    rd_chk("ret ip", OFS_IP, 32'h0000_0102);
    rd_chk("ret flags", OFS_FLAGS, 32'h0000_0003);
    rd_chk("sp pop", OFS_SP, 32'h0000_0000);
    do_op(OP_INTO, 1'b0, 32'h0000_0009, 32'h0000_0001);
    trap_chk(32'h0000_0102, 1'b0, 8'h00);
    do_op(OP_INTO, 1'b0, 32'h0000_0009, 32'h0000_0002);
    trap_chk(32'h0000_1000 + {22'h0, OVF_VEC, 2'b00}, 1'b1, OVF_VEC);
    // signed bounds -4 .. 10
    bus_write(OFS_BLO, 32'hFFFF_FFFC);
    bus_write(OFS_BHI, 32'h0000_000A);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: v = 32'hFFFF_FFFB;
        1: v = 32'hFFFF_FFFC;
        2: v = 32'h0000_000A;
        3: v = 32'h0000_000B;
        default: v = 32'h8000_0000;
      endcase
      bus_write(OFS_VALUE, v);
      do_op(OP_BOUND, 1'b0, 32'h0000_0000, 32'h0000_0000);
      trap_chk((i == 1 || i == 2) ? 32'h0000_0102 : 32'h0000_1000 + {22'h0, RANGE_VEC, 2'b00},
               !(i == 1 || i == 2), RANGE_VEC);
    end
    complete_run();
  end

  // a hang is far beyond the fewer than a thousand cycles the tests take
  initial begin
    repeat (30000) @(posedge i_core_clk);
    bad_count++;
    complete_run();
  end
endmodule

/* File: rtl/cbst_branch_eval.sv */
`timescale 1ns/100ps
module cbst_branch_eval import cbst_pkg::*; (
  input  wire cbst_op_t    i_op,
  input  wire logic        i_a16,
  input  wire logic [31:0] i_count,
  input  wire logic        i_zf,
  input  wire logic [31:0] i_ip,
  input  wire logic [31:0] i_len,
  input  wire logic [31:0] i_rel,
  output logic [31:0]      o_count,
  output logic             o_taken
);
  logic [31:0] dec;
  logic        dec_nz;
  always_comb begin
    // plain wrap, no zero special case
    dec = i_a16 ? {i_count[31:16], i_count[15:0] - 16'h0001}
                : i_count - 32'h0000_0001;
    dec_nz = i_a16 ? (dec[15:0] != 16'h0000) : (dec != 32'h0000_0000);
    o_count = i_count;
    o_taken = 1'b0;
    case (i_op)
      OP_LOOP: begin
        o_count = dec;
        o_taken = dec_nz;
      end
      OP_LOOP_EQ: begin
        o_count = dec;
        o_taken = dec_nz && i_zf;
      end
      OP_LOOP_NE: begin
        o_count = dec;
        o_taken = dec_nz && !i_zf;
      end
      OP_JCX32: o_taken = (i_count == 32'h0000_0000);
      OP_JCX16: o_taken = (i_count[15:0] == 16'h0000);
      default: o_taken = 1'b0;
    endcase
  end
endmodule

/* File: rtl/cbst_core.sv */
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module cbst_core import cbst_pkg::*; (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_busy
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cbst_state_t    state;
  cbst_state_t    next_state;
  cbst_op_t       op;
  cbst_op_t       next_op;
  logic           a16;
  logic           next_a16;
  logic [DW-1:0]  count_reg32;
  logic [DW-1:0]  next_count_reg32;
  logic [DW-1:0]  instr_pointer;
  logic [DW-1:0]  next_instr_pointer;
  logic [DW-1:0]  flags_word;
  logic [DW-1:0]  next_flags_word;
  logic [DW-1:0]  operand;
  logic [DW-1:0]  next_operand;
  logic [DW-1:0]  len;
  logic [DW-1:0]  next_len;
  logic [DW-1:0]  blo;
  logic [DW-1:0]  next_blo;
  logic [DW-1:0]  bhi;
  logic [DW-1:0]  next_bhi;
  logic [DW-1:0]  value;
  logic [DW-1:0]  next_value;
  logic [DW-1:0]  vbase;
  logic [DW-1:0]  next_vbase;
  logic [SAW-1:0] sp;
  logic [SAW-1:0] next_sp;
  logic [7:0]     last_vec;
  logic [7:0]     next_last_vec;
  logic           taken;
  logic           next_taken;
  logic           trapped;
  logic           next_trapped;
  logic           rd_valid;
  logic           next_rd_valid;
  logic [DW-1:0]  rdata;
  logic [DW-1:0]  next_rdata;
  logic [DW-1:0]  rd_mux;
  logic [DW-1:0]  seq_ip;
  logic [DW-1:0]  ev_count;
  logic           ev_taken;
  logic           wr_ok;
  logic           out_of_range;

  cbst_stk_if stk ();

  cbst_stack_mem u_mem (
    .i_clk (i_core_clk),
    .stk   (stk)
  );

  cbst_branch_eval u_eval (
    .i_op    (op),
    .i_a16   (a16),
    .i_count (count_reg32),
    .i_zf    (flags_word[ZF_BIT]),
    .i_ip    (instr_pointer),
    .i_len   (len),
    .i_rel   (operand),
    .o_count (ev_count),
    .o_taken (ev_taken)
  );

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // writes stall while a command runs so software never races the engine
  assign wr_ok = i_avs_write && (state == ST_IDLE);
  assign o_avs_waitrequest = (i_avs_read && !rd_valid) ||
                             (i_avs_write && (state != ST_IDLE));
  assign o_avs_readdata = rdata;
  assign o_busy = (state != ST_IDLE);
  assign seq_ip = instr_pointer + len;
  assign out_of_range = ($signed(value) < $signed(blo)) ||
                        ($signed(value) > $signed(bhi));

  always_comb begin
    if (i_avs_address == OFS_COUNT) rd_mux = count_reg32;
    else if (i_avs_address == OFS_IP) rd_mux = instr_pointer;
    else if (i_avs_address == OFS_FLAGS) rd_mux = flags_word;
    else if (i_avs_address == OFS_OPND) rd_mux = operand;
    else if (i_avs_address == OFS_LEN) rd_mux = len;
    else if (i_avs_address == OFS_BLO) rd_mux = blo;
    else if (i_avs_address == OFS_BHI) rd_mux = bhi;
    else if (i_avs_address == OFS_VALUE) rd_mux = value;
    else if (i_avs_address == OFS_SP) rd_mux = {28'h0000000, sp};
    else if (i_avs_address == OFS_VBASE) rd_mux = vbase;
    else if (i_avs_address == OFS_STATUS)
      rd_mux = {16'h0000, last_vec, 5'h00, trapped, taken, o_busy};
    else if (i_avs_address == OFS_CMD)
      rd_mux = {23'h000000, a16, 4'h0, op};
    else rd_mux = RST_WORD;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_op = op;
    next_a16 = a16;
    next_count_reg32 = count_reg32;
    next_instr_pointer = instr_pointer;
    next_flags_word = flags_word;
    next_operand = operand;
    next_len = len;
    next_blo = blo;
    next_bhi = bhi;
    next_value = value;
    next_vbase = vbase;
    next_sp = sp;
    next_last_vec = last_vec;
    next_taken = taken;
    next_trapped = trapped;
    next_rd_valid = i_avs_read && !rd_valid;
    next_rdata = (i_avs_read && !rd_valid) ? rd_mux : rdata;
    stk.we = 1'b0;
    stk.addr = sp;
    stk.wdata = flags_word;
    if (wr_ok) begin
      if (i_avs_address == OFS_COUNT)
        next_count_reg32 = be_merge(count_reg32, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_IP)
        next_instr_pointer = be_merge(instr_pointer, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_FLAGS)
        next_flags_word = be_merge(flags_word, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_OPND)
        next_operand = be_merge(operand, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_LEN)
        next_len = be_merge(len, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_BLO)
        next_blo = be_merge(blo, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_BHI)
        next_bhi = be_merge(bhi, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_VALUE)
        next_value = be_merge(value, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_SP && i_avs_byteenable[0])
        next_sp = i_avs_writedata[SAW-1:0];
      else if (i_avs_address == OFS_VBASE)
        next_vbase = be_merge(vbase, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == OFS_CMD && i_avs_byteenable[0]) begin
        // equal/zero and unequal/nonzero forms are one code each
        next_op = cbst_op_t'(i_avs_writedata[3:0]);
        next_a16 = i_avs_writedata[CMD_A16_BIT];
        next_taken = 1'b0;
        next_trapped = 1'b0;
        next_state = ST_EXEC;
      end
    end
    case (state)
      ST_EXEC: begin
        next_state = ST_IDLE;
        case (op)
          OP_INT: begin
            next_last_vec = operand[7:0];
            next_trapped = 1'b1;
            next_state = ST_PUSH_FL;
          end
          OP_INTO: begin
            if (flags_word[OF_BIT]) begin
              next_last_vec = OVF_VEC;
              next_trapped = 1'b1;
              next_state = ST_PUSH_FL;
            end else begin
              next_instr_pointer = seq_ip;
            end
          end
          OP_BOUND: begin
            if (out_of_range) begin
              next_last_vec = RANGE_VEC;
              next_trapped = 1'b1;
              next_state = ST_PUSH_FL;
            end else begin
              next_instr_pointer = seq_ip;
            end
          end
          OP_HANDLER_RETURN: next_state = ST_POP_IP;
          default: begin
            // flags are never written here, only the count, taken and the pointer
            next_count_reg32 = ev_count;
            next_taken = ev_taken;
            next_instr_pointer = ev_taken ? rel_target(instr_pointer, len, operand)
                                          : seq_ip;
          end
        endcase
      end
      ST_PUSH_FL: begin
        stk.we = 1'b1;
        stk.addr = sp - 4'h1;
        stk.wdata = flags_word;
        next_sp = sp - 4'h1;
        next_state = ST_PUSH_IP;
      end
      ST_PUSH_IP: begin
        stk.we = 1'b1;
        stk.addr = sp - 4'h1;
        stk.wdata = seq_ip;
        next_sp = sp - 4'h1;
        next_instr_pointer = vbase + {22'h000000, last_vec, 2'b00};
        next_state = ST_IDLE;
      end
      ST_POP_IP: begin
        // pointer was pushed last, so it comes back first
        next_instr_pointer = stk.rdata;
        stk.addr = sp + 4'h1;
        next_sp = sp + 4'h1;
        next_state = ST_POP_FL;
      end
      ST_POP_FL: begin
        next_flags_word = stk.rdata;
        next_sp = sp + 4'h1;
        next_state = ST_IDLE;
      end
      default: begin
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= OP_NOP;
      a16 <= 1'b0;
      count_reg32 <= RST_WORD;
      instr_pointer <= RST_WORD;
      flags_word <= RST_WORD;
      operand <= RST_WORD;
      len <= RST_WORD;
      blo <= RST_WORD;
      bhi <= RST_WORD;
      value <= RST_WORD;
      vbase <= RST_WORD;
      sp <= RST_SP;
      last_vec <= 8'h00;
      taken <= 1'b0;
      trapped <= 1'b0;
      rd_valid <= 1'b0;
      rdata <= RST_WORD;
    end else begin
      state <= next_state;
      op <= next_op;
      a16 <= next_a16;
      count_reg32 <= next_count_reg32;
      instr_pointer <= next_instr_pointer;
      flags_word <= next_flags_word;
      operand <= next_operand;
      len <= next_len;
      blo <= next_blo;
      bhi <= next_bhi;
      value <= next_value;
      vbase <= next_vbase;
      sp <= next_sp;
      last_vec <= next_last_vec;
      taken <= next_taken;
      trapped <= next_trapped;
      rd_valid <= next_rd_valid;
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  logic ex;
  assign ex = (state == ST_EXEC);

  sequence s_push;
    state == ST_PUSH_FL ##1 state == ST_PUSH_IP ##1 state == ST_IDLE;
  endsequence
  sequence s_pop;
    state == ST_POP_IP ##1 state == ST_POP_FL ##1 state == ST_IDLE;
  endsequence

  loop_dec_a: assert property (ex && op == OP_LOOP && !a16 |=>
    count_reg32 == $past(count_reg32) - 32'h0000_0001) else $error("count not decremented");
  loop_half_a: assert property (ex && op == OP_LOOP && a16 |=>
    count_reg32[31:16] == $past(count_reg32[31:16])) else $error("upper count half changed");
  loop_take_a: assert property (ex && op == OP_LOOP && !a16 && count_reg32 != 32'h1 |=>
    taken && instr_pointer == $past(instr_pointer) + $past(len) + $past(operand))
    else $error("loop target wrong");
  loop_exit_a: assert property (ex && op == OP_LOOP && !a16 && count_reg32 == 32'h1 |=>
    !taken && instr_pointer == $past(instr_pointer) + $past(len)) else $error("loop did not exit");
  loop_wrap_a: assert property (ex && op == OP_LOOP && !a16 && count_reg32 == 32'h0 |=>
    taken && count_reg32 == 32'hFFFF_FFFF) else $error("zero count did not wrap");
  loop_eq_a: assert property (ex && op == OP_LOOP_EQ && !a16 |=>
    taken == ($past(count_reg32) != 32'h1 && $past(flags_word[ZF_BIT]))) else $error("while-equal wrong");
  loop_ne_a: assert property (ex && op == OP_LOOP_NE && !a16 |=>
    taken == ($past(count_reg32) != 32'h1 && !$past(flags_word[ZF_BIT]))) else $error("while-unequal wrong");
  empty32_a: assert property (ex && op == OP_JCX32 |=> count_reg32 == $past(count_reg32) &&
    taken == ($past(count_reg32) == 32'h0)) else $error("empty-count jump wrong");
  empty16_a: assert property (ex && op == OP_JCX16 |=>
    taken == ($past(count_reg32[15:0]) == 16'h0)) else $error("16-bit empty-count jump wrong");
  trap_seq_a: assert property (ex && op == OP_INT |=> s_push ##0
    instr_pointer == vbase + {22'h0, last_vec, 2'b00} && last_vec == $past(operand[7:0], 3))
    else $error("vectored trap sequence wrong");
  push_data_a: assert property (state == ST_PUSH_FL |-> stk.we && stk.wdata == flags_word
    ##1 stk.we && stk.wdata == $past(instr_pointer) + $past(len)) else $error("trap push wrong");
  ret_seq_a: assert property (ex && op == OP_HANDLER_RETURN |=> s_pop ##0
    sp == $past(sp, 3) + 4'h2) else $error("handler return pop wrong");
  ovf_clear_a: assert property (ex && op == OP_INTO && !flags_word[OF_BIT] |=>
    state == ST_IDLE && !trapped) else $error("overflow trap without flag");
  range_chk_a: assert property (ex && op == OP_BOUND |=>
    trapped == ($signed($past(value)) < $signed($past(blo)) ||
                $signed($past(value)) > $signed($past(bhi)))) else $error("range check wrong");
  flags_keep_a: assert property (state != ST_POP_FL && !(wr_ok && i_avs_address == OFS_FLAGS) |=>
    flags_word == $past(flags_word)) else $error("flags changed unexpectedly");
endmodule

/* File: rtl/cbst_stack_mem.sv */
`timescale 1ns/100ps
module cbst_stack_mem import cbst_pkg::*; (
  input  wire logic i_clk,
  cbst_stk_if.mem   stk
);
  logic [DW-1:0] mem [STK_DEPTH];
  // read data registered: one cycle from address to data
  always_ff @(posedge i_clk) begin
    if (stk.we) mem[stk.addr] <= stk.wdata;
    stk.rdata <= mem[stk.addr];
  end
endmodule
